/* logic/fspr_consts.svh */
`ifndef FSPR_CONSTS_SVH
`define FSPR_CONSTS_SVH

// Register offsets in configuration space
`define FSPR_OFF_ROLE     8'h68
`define FSPR_OFF_AUX      8'h6c
`define FSPR_OFF_TIMER    8'h70
`define FSPR_OFF_POLICY   8'h74

// Reset values
`define FSPR_RST_ROLE     32'h04001060
`define FSPR_RST_AUX      32'h04000800
`define FSPR_RST_TIMER    32'h80000000
`define FSPR_RST_POLICY   32'h0a730102

// Bits that configuration writes may change
`define FSPR_WMASK_ROLE   32'hffffffff
`define FSPR_WMASK_AUX    32'hffffffff
`define FSPR_WMASK_TIMER  32'h7fff1fff
`define FSPR_WMASK_POLICY 32'h00003f7f

// Bits that the default loader may change
`define FSPR_LMASK_ROLE   32'h00006000
`define FSPR_LMASK_TIMER  32'hffff7fff
`define FSPR_LMASK_POLICY 32'h7fffffff

// Field positions
`define FSPR_B_ROLE_EN    1
`define FSPR_B_HOT_SUPP   2
`define FSPR_B_ROLE_DN    3
`define FSPR_B_RPL_EN     12
`define FSPR_B_ACK_EN     30
`define FSPR_B_VGA        31
`define FSPR_B_SF         0
`define FSPR_B_ARB        3
`define FSPR_B_CREDIT     4
`define FSPR_B_ORD_EGR    5
`define FSPR_B_ORD_TAG    6
`define FSPR_B_NP_SF      7

// Internal timer values in symbol times, indexed by link width
`define FSPR_ACK_X1       14'd237
`define FSPR_ACK_X2       14'd128
`define FSPR_ACK_X4       14'd73
`define FSPR_ACK_X8       14'd67
`define FSPR_ACK_X12      14'd58
`define FSPR_RPL_X1       12'd711
`define FSPR_RPL_X2       12'd384
`define FSPR_RPL_X4       12'd219
`define FSPR_RPL_X8       12'd201
`define FSPR_RPL_X12      12'd174

`endif

/* logic/fspr_pkg.sv */
package fspr_pkg;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } fspr_cfg_req_t;

  typedef struct packed {
    logic        valid;
    logic [7:0]  addr;
    logic [31:0] data;
  } fspr_load_t;

  typedef struct packed {
    logic       store_forward;
    logic [1:0] ct_threshold;
    logic       arb_hold;
    logic       credit_all;
    logic       order_egress;
    logic       order_cpl_tag;
    logic       np_store_forward;
  } fspr_policy_t;

endpackage : fspr_pkg

/* logic/fspr_regs.sv */
`timescale 1ns/10ps
`default_nettype none
`include "fspr_consts.svh"
// Notes on behaviour
// RULE_01 - Role changes apply only while role-change permission is set.
// RULE_02 - Role select one means downstream port, zero means upstream port.
// RULE_03 - Upstream link loss fires hot reset downstream unless suppressed.
// RULE_04 - Role register bits 14:13 accept defaults from the EEPROM loader.
// RULE_05 - Twelve-bit user replay timeout in bits 11:0, zero at reset.
// RULE_06 - Replay override enable selects the user replay timeout.
// RULE_07 - Fourteen-bit user ack latency in bits 29:16, zero at reset.
// RULE_08 - Ack override enable selects the user ack latency.
// RULE_09 - Bit 0 set means store-and-forward, clear means cut-through.
// RULE_10 - Threshold 00 at midpoint, else 1-3 cycles earlier; resets to 01.
// RULE_11 - Arbitration bit set keeps the grant while request pends.
// RULE_12 - Arbitration bit clear moves only to ports with enough credit.
// RULE_13 - Credit mode set releases all types together, else per type.
// RULE_14 - Bit 5 set orders packets across different egress ports.
// RULE_15 - Bit 6 set orders completions with different tags.
// RULE_16 - Read-only bit 7 set forces store-and-forward for non-posted.
// RULE_17 - Timer and policy defaults loadable by serial loader or reset.
// RULE_18 - Read-only VGA decode enable in bit 31, resets to one.
// RULE_19 - Without override, timers come from negotiated width and speed; the code uses link_width only and ignores link_gen2.
module fspr_regs (
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  input  wire fspr_pkg::fspr_cfg_req_t cfg_req,
  output var  logic [31:0]           cfg_rdata,
  output var  logic                  cfg_rvalid,
  input  wire fspr_pkg::fspr_load_t  load,
  input  wire logic                  up_link_down,
  input  wire logic [3:0]            link_width,
  input  wire logic                  link_gen2,
  output var  logic                  role_downstream,
  output var  logic                  hot_reset_fire,
  output var  logic                  vga_decode_en,
  output var  logic [11:0]           replay_timeout,
  output var  logic [13:0]           ack_latency,
  output var  fspr_pkg::fspr_policy_t policy
);
  import fspr_pkg::*;

  logic [31:0]  role_q,   role_d;
  logic [31:0]  aux_q,    aux_d;
  logic [31:0]  timer_q,  timer_d;
  logic [31:0]  pol_q,    pol_d;
  logic [31:0]  rdata_q,  rdata_d;
  logic         rvalid_q, rvalid_d;
  logic         dn_q,     dn_d;
  logic         hot_q,    hot_d;
  logic [11:0]  rpl_q,    rpl_d;
  logic [13:0]  ack_q,    ack_d;
  fspr_policy_t polo_q,   polo_d;
  logic [2:0]   ld_sync_q;
  logic         ld_filt_q, ld_filt_d;

  function automatic logic [31:0] be_mask(input logic [3:0] be);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{be[i]}};
    end
    return m;
  endfunction : be_mask

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [31:0] mask);
    return (old_v & ~mask) | (new_v & mask);
  endfunction : merge

  // Wider links need fewer symbol times; link_gen2 does not enter either table here
  function automatic logic [13:0] int_ack(input logic [3:0] w);
    logic [13:0] v;
    unique case (w)
      4'h1:    v = `FSPR_ACK_X1;
      4'h2:    v = `FSPR_ACK_X2;
      4'h4:    v = `FSPR_ACK_X4;
      4'h8:    v = `FSPR_ACK_X8;
      4'hc:    v = `FSPR_ACK_X12;
      default: v = `FSPR_ACK_X1;
    endcase
    return v;
  endfunction : int_ack

  function automatic logic [11:0] int_rpl(input logic [3:0] w);
    logic [11:0] v;
    unique case (w)
      4'h1:    v = `FSPR_RPL_X1;
      4'h2:    v = `FSPR_RPL_X2;
      4'h4:    v = `FSPR_RPL_X4;
      4'h8:    v = `FSPR_RPL_X8;
      4'hc:    v = `FSPR_RPL_X12;
      default: v = `FSPR_RPL_X1;
    endcase
    return v;
  endfunction : int_rpl

  // Register file: loader applied first so a same-cycle host write wins
  always_comb begin
    logic [31:0] wm;
    wm      = be_mask(cfg_req.be);
    role_d  = role_q;
    aux_d   = aux_q;
    timer_d = timer_q;
    pol_d   = pol_q;
    if (load.valid) begin
      unique case (load.addr)
        `FSPR_OFF_ROLE:   role_d  = merge(role_d, load.data,
                                          `FSPR_LMASK_ROLE); // RULE_04
        `FSPR_OFF_TIMER:  timer_d = merge(timer_d, load.data,
                                          `FSPR_LMASK_TIMER); // RULE_17
        `FSPR_OFF_POLICY: pol_d   = merge(pol_d, load.data,
                                          `FSPR_LMASK_POLICY); // RULE_17
        default: ;
      endcase
    end
    if (cfg_req.wr) begin
      unique case (cfg_req.addr)
        `FSPR_OFF_ROLE:   role_d  = merge(role_d, cfg_req.wdata,
                                          wm & `FSPR_WMASK_ROLE);
        `FSPR_OFF_AUX:    aux_d   = merge(aux_d, cfg_req.wdata,
                                          wm & `FSPR_WMASK_AUX);
        `FSPR_OFF_TIMER:  timer_d = merge(timer_d, cfg_req.wdata,
                                          wm & `FSPR_WMASK_TIMER); // RULE_05
        `FSPR_OFF_POLICY: pol_d   = merge(pol_d, cfg_req.wdata,
                                          wm & `FSPR_WMASK_POLICY);
        default: ;
      endcase
    end
    rvalid_d = cfg_req.rd;
    rdata_d  = '0;
    if (cfg_req.rd) begin
      unique case (cfg_req.addr)
        `FSPR_OFF_ROLE:   rdata_d = role_q;
        `FSPR_OFF_AUX:    rdata_d = aux_q;
        `FSPR_OFF_TIMER:  rdata_d = timer_q;
        `FSPR_OFF_POLICY: rdata_d = pol_q;
        default:          rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      role_q   <= `FSPR_RST_ROLE;
      aux_q    <= `FSPR_RST_AUX;
      timer_q  <= `FSPR_RST_TIMER; // RULE_18
      pol_q    <= `FSPR_RST_POLICY; // RULE_10
      rdata_q  <= '0;
      rvalid_q <= 1'b0;
    end else begin
      role_q   <= role_d;
      aux_q    <= aux_d;
      timer_q  <= timer_d;
      pol_q    <= pol_d;
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // Link-down pin synchroniser; glitches shorter than two cycles are dropped
  always_comb begin
    ld_filt_d = ld_filt_q;
    if (ld_sync_q[1] == ld_sync_q[2]) begin
      ld_filt_d = ld_sync_q[2];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ld_sync_q <= '0;
      ld_filt_q <= 1'b0;
    end else begin
      ld_sync_q <= {ld_sync_q[1:0], up_link_down};
      ld_filt_q <= ld_filt_d;
    end
  end

  // Effective controls seen by the switch core
  always_comb begin
    dn_d = dn_q;
    if (role_q[`FSPR_B_ROLE_EN]) begin // RULE_01
      dn_d = role_q[`FSPR_B_ROLE_DN]; // RULE_02
    end
    hot_d = ld_filt_q && !dn_q && !role_q[`FSPR_B_HOT_SUPP]; // RULE_03
    if (timer_q[`FSPR_B_RPL_EN]) begin // RULE_06
      rpl_d = timer_q[11:0];
    end else begin
      rpl_d = int_rpl(link_width); // RULE_19
    end
    if (timer_q[`FSPR_B_ACK_EN]) begin // RULE_08
      ack_d = timer_q[29:16]; // RULE_07
    end else begin
      ack_d = int_ack(link_width); // RULE_19
    end
    polo_d.store_forward    = pol_q[`FSPR_B_SF]; // RULE_09
    polo_d.ct_threshold     = pol_q[2:1]; // RULE_10
    polo_d.arb_hold         = pol_q[`FSPR_B_ARB]; // RULE_11 RULE_12
    polo_d.credit_all       = pol_q[`FSPR_B_CREDIT]; // RULE_13
    polo_d.order_egress     = pol_q[`FSPR_B_ORD_EGR]; // RULE_14
    polo_d.order_cpl_tag    = pol_q[`FSPR_B_ORD_TAG]; // RULE_15
    polo_d.np_store_forward = pol_q[`FSPR_B_NP_SF]; // RULE_16
  end

  // Speed input is reserved for per-rate tables; symbol counts match
  logic unused_speed;
  assign unused_speed = link_gen2;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      dn_q   <= 1'b0;
      hot_q  <= 1'b0;
      rpl_q  <= `FSPR_RPL_X1;
      ack_q  <= `FSPR_ACK_X1;
      polo_q <= '0;
    end else begin
      dn_q   <= dn_d;
      hot_q  <= hot_d;
      rpl_q  <= rpl_d;
      ack_q  <= ack_d;
      polo_q <= polo_d;
    end
  end

  assign cfg_rdata       = rdata_q;
  assign cfg_rvalid      = rvalid_q;
  assign role_downstream = dn_q;
  assign hot_reset_fire  = hot_q;
  assign vga_decode_en   = timer_q[`FSPR_B_VGA];
  assign replay_timeout  = rpl_q;
  assign ack_latency     = ack_q;
  assign policy          = polo_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_host_write_timer;
    cfg_req.wr && cfg_req.addr == `FSPR_OFF_TIMER && !load.valid;
  endsequence

  sequence s_timer_ro_kept;
    timer_q[31] == $past(timer_q[31]) && timer_q[15:13] ==
      $past(timer_q[15:13]);
  endsequence

  chk_role_locked: assert property ( // RULE_01
    !role_q[`FSPR_B_ROLE_EN] |=> dn_q == $past(dn_q))
    else $error("role changed while locked");

  chk_role_follow: assert property ( // RULE_02
    role_q[`FSPR_B_ROLE_EN] |=> dn_q == $past(role_q[`FSPR_B_ROLE_DN]))
    else $error("role did not follow select");

  chk_hot_fire: assert property ( // RULE_03
    (ld_filt_q && !dn_q && !role_q[`FSPR_B_HOT_SUPP]) |=> hot_q)
    else $error("hot reset not fired");

  chk_hot_suppr: assert property ( // RULE_03
    role_q[`FSPR_B_HOT_SUPP] |=> !hot_q)
    else $error("hot reset fired while suppressed");

  chk_load_role_bits: assert property ( // RULE_04
    (load.valid && load.addr == `FSPR_OFF_ROLE && !cfg_req.wr)
      |=> role_q[14:13] == $past(load.data[14:13]))
    else $error("loader did not set role bits");

  chk_replay_select: assert property ( // RULE_06
    timer_q[`FSPR_B_RPL_EN] |=> rpl_q == $past(timer_q[11:0]))
    else $error("replay override not used");

  chk_ack_select: assert property ( // RULE_08
    timer_q[`FSPR_B_ACK_EN] |=> ack_q == $past(timer_q[29:16]))
    else $error("ack override not used");

  chk_timer_ro_bits: assert property ( // RULE_18
    s_host_write_timer |=> s_timer_ro_kept)
    else $error("host changed read-only timer bits");

  // Gated on reset_n: the output stage still shows zero one cycle on
  chk_policy_sf: assert property ( // RULE_09
    reset_n |=> policy.store_forward == $past(pol_q[`FSPR_B_SF])
      && policy.ct_threshold == $past(pol_q[2:1]))
    else $error("forwarding mode mismatch");

  chk_policy_levels: assert property ( // RULE_11 RULE_13 RULE_14 RULE_15
    reset_n |=> policy.arb_hold == $past(pol_q[`FSPR_B_ARB])
      && policy.credit_all == $past(pol_q[`FSPR_B_CREDIT])
      && policy.order_egress == $past(pol_q[`FSPR_B_ORD_EGR])
      && policy.order_cpl_tag == $past(pol_q[`FSPR_B_ORD_TAG])
      && policy.np_store_forward == $past(pol_q[`FSPR_B_NP_SF]))
    else $error("policy control levels mismatch");

  chk_policy_ro_bit: assert property ( // RULE_16
    (cfg_req.wr && cfg_req.addr == `FSPR_OFF_POLICY && !load.valid)
      |=> pol_q[`FSPR_B_NP_SF] == $past(pol_q[`FSPR_B_NP_SF]))
    else $error("host changed read-only forwarding bit");

  chk_auto_timers: assert property ( // RULE_19
    !timer_q[`FSPR_B_ACK_EN] && link_width == 4'h4
      |=> ack_q == `FSPR_ACK_X4)
    else $error("internal ack latency wrong");

  chk_load_timer: assert property ( // RULE_17
    (load.valid && load.addr == `FSPR_OFF_TIMER && !cfg_req.wr)
      |=> timer_q[12:0] == $past(load.data[12:0]))
    else $error("loader did not set timer defaults");

  // A downstream port never forwards a hot reset, whatever its pin says
  chk_hot_role: assert property ( // RULE_03
    dn_q |=> !hot_q)
    else $error("hot reset fired on downstream role");

endmodule : fspr_regs
`default_nettype wire

/* tb/fspr_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module fspr_host_model (
  input  wire logic                    clk,
  output var  fspr_pkg::fspr_cfg_req_t req,
  output var  fspr_pkg::fspr_load_t    load,
  input  wire logic [31:0]             rdata,
  input  wire logic                    rvalid
);
  import fspr_pkg::*;

  initial begin
    req  = '0;
    load = '0;
  end
  // Data is inverted on release so a stale bus never looks valid
  task automatic wr(input logic [7:0] a, input logic [3:0] b,
                    input logic [31:0] d);
    @(posedge clk);
    req.wr    <= 1'b1;
    req.addr  <= a;
    req.be    <= b;
    req.wdata <= d;
    @(posedge clk);
    req.wr    <= 1'b0;
    req.wdata <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic v);
    @(posedge clk);
    req.rd   <= 1'b1;
    req.addr <= a;
    @(posedge clk);
    req.rd   <= 1'b0;
    #1;
    d = rdata;
    v = rvalid;
  endtask : rd
  task automatic ld(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    load.valid <= 1'b1;
    load.addr  <= a;
    load.data  <= d;
    @(posedge clk);
    load.valid <= 1'b0;
    load.data  <= ~d;
  endtask : ld
endmodule : fspr_host_model
`default_nettype wire

/* tb/tb_switch_forwarding_policy_regs.sv */
`timescale 1ns/10ps
`default_nettype none
`include "fspr_consts.svh"
module tb_switch_forwarding_policy_regs;
  import fspr_pkg::*;
  logic           clk;
  logic           reset_n;
  fspr_cfg_req_t  req;
  fspr_load_t     load;
  logic [31:0]    rdata;
  logic           rvalid;
  logic           link_down;
  logic [3:0]     width;
  logic           gen2;
  logic           role_dn;
  logic           hot_fire;
  logic           vga;
  logic [11:0]    rpl;
  logic [13:0]    ack;
  fspr_policy_t   pol;
  int             fail_count;
  int             num_checks;
  logic [3:0]  wt [5] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'hc};
  logic [13:0] at [5] = '{`FSPR_ACK_X1, `FSPR_ACK_X2, `FSPR_ACK_X4,
                          `FSPR_ACK_X8, `FSPR_ACK_X12};
  logic [11:0] rt [5] = '{`FSPR_RPL_X1, `FSPR_RPL_X2, `FSPR_RPL_X4,
                          `FSPR_RPL_X8, `FSPR_RPL_X12};
  logic [31:0] pv [10] = '{32'h0, 32'h1, 32'h2, 32'h4, 32'h6, 32'h8,
                           32'h10, 32'h20, 32'h40, 32'h80};
  logic [31:0] rv [4] = '{32'h04001068, 32'h0400106a, 32'h04001062,
                          32'h04001068};
  logic        re [4] = '{1'b0, 1'b1, 1'b0, 1'b0};
  fspr_regs DUT (
    .clk(clk), .reset_n(reset_n), .cfg_req(req), .cfg_rdata(rdata),
    .cfg_rvalid(rvalid), .load(load), .up_link_down(link_down),
    .link_width(width), .link_gen2(gen2), .role_downstream(role_dn),
    .hot_reset_fire(hot_fire), .vga_decode_en(vga),
    .replay_timeout(rpl), .ack_latency(ack), .policy(pol)
  );
  fspr_host_model host (
    .clk(clk), .req(req), .load(load), .rdata(rdata), .rvalid(rvalid)
  );
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic test_done();
    $display("checks %0d failures %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done
  task automatic check(input string n, input logic [31:0] s, e);
    num_checks++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic        v;
    host.rd(a, d, v);
    check("rvalid", {31'h0, v}, 32'h1);
    check($sformatf("reg %h", a), d, e);
  endtask : rchk
  // Bounded wait; the sync filter makes the exact delay a few cycles
  task automatic wait_fire(input logic e);
    int i;
    for (i = 0; i < 12 && hot_fire !== e; i++) tick(1);
    check("hot_reset_fire", {31'h0, hot_fire}, {31'h0, e});
    if (hot_fire !== e) test_done();
  endtask : wait_fire
  initial begin
    int i;
    logic [31:0] e;
    reset_n = 1'b0;
    link_down = 1'b0;
    width = 4'd1;
    gen2 = 1'b0;
    fail_count = 0;
    num_checks = 0;
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    tick(2);
    check("policy", {24'h0, pol}, 32'h20);
    check("vga", {31'h0, vga}, 32'h1);
    rchk(8'h68, 32'h04001060);
    rchk(8'h6c, 32'h04000800);
    rchk(8'h70, 32'h80000000);
    rchk(8'h74, `FSPR_RST_POLICY);
    rchk(8'h80, 32'h0);
    host.wr(8'h6c, 4'h1, 32'hffffffff);
    rchk(8'h6c, 32'h040008ff);
    host.wr(8'h70, 4'hf, 32'h40051000);
    rchk(8'h70, 32'hc0051000);
    tick(1);
    check("ack", {18'h0, ack}, 32'h5);
    check("rpl", {20'h0, rpl}, 32'h0);
    host.wr(8'h70, 4'hf, 32'hffffffff);
    rchk(8'h70, 32'hffff1fff);
    tick(1);
    check("ack", {18'h0, ack}, 32'h3fff);
    check("rpl", {20'h0, rpl}, 32'hfff);
    host.wr(8'h70, 4'hf, 32'h0);
    for (i = 0; i < 5; i++) begin
      width <= wt[i];
      gen2 <= i[0];
      tick(3);
      check("ack", {18'h0, ack}, {18'h0, at[i]});
      check("rpl", {20'h0, rpl}, {20'h0, rt[i]});
    end
    for (i = 0; i < 10; i++) begin
      host.wr(8'h74, 4'hf, pv[i]);
      e = (`FSPR_RST_POLICY & ~`FSPR_WMASK_POLICY) |
          (pv[i] & `FSPR_WMASK_POLICY);
      rchk(8'h74, e);
      tick(1);
      check("policy", {24'h0, pol}, {24'h0, e[0], e[2:1], e[3], e[4],
            e[5], e[6], e[7]});
    end
    host.ld(8'h74, 32'h80000080);
    rchk(8'h74, 32'h00000080);
    check("policy", {24'h0, pol}, 32'h1);
    host.ld(8'h70, 32'hc0001abc);
    rchk(8'h70, 32'hc0001abc);
    check("rpl", {20'h0, rpl}, 32'habc);
    for (i = 0; i < 4; i++) begin
      host.wr(8'h68, 4'hf, rv[i]);
      tick(2);
      check("role", {31'h0, role_dn}, {31'h0, re[i]});
    end
    link_down <= 1'b1;
    wait_fire(1'b1);
    link_down <= 1'b0;
    wait_fire(1'b0);
    host.wr(8'h68, 4'hf, 32'h0400106c);
    link_down <= 1'b1;
    tick(10);
    check("hot_supp", {31'h0, hot_fire}, 32'h0);
    check("role", {31'h0, role_dn}, 32'h0);
    host.wr(8'h68, 4'hf, 32'h0400106e);
    host.wr(8'h68, 4'hf, 32'h0400106a);
    tick(10);
    check("hot_dn", {31'h0, hot_fire}, 32'h0);
    check("role", {31'h0, role_dn}, 32'h1);
    link_down <= 1'b0;
    host.ld(8'h68, 32'hffffffff);
    rchk(8'h68, 32'h0400706a);
    host.ld(8'h6c, 32'hffffffff);
    rchk(8'h6c, 32'h040008ff);
    test_done();
  end
endmodule : tb_switch_forwarding_policy_regs
`default_nettype wire
